//--- kbe_core.sv
// keyboard encoder housekeeping: lookup, debounce, rollover, alarm, serial bus
`timescale 1ns/1ns
`default_nettype none
`include "kbe_cfg.svh"
module kbe_core
	import kbe_pkg::*;
#(
	parameter logic [3:0] DEBOUNCE_MOD = 4'(`KBE_DEBOUNCE_DEF),
	parameter logic [1:0] STATIC_SLOT_SEL = 2'h0,
	parameter logic ALARM_ON_BUS = 1'b1,
	parameter logic [`KBE_CODE_W*2*`KBE_KEYS-1:0] LOOKUP_INIT = '0
)
(
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic I_WORD_SYNC_MARKER,
	input wire logic I_BUS,
	input wire logic I_KEY_RETURN,
	input wire logic [4:0] I_SCAN_POS,
	input wire logic I_SCAN_BLOCK,
	input wire logic I_UPPER_CASE,
	input wire logic I_CLEAR_KEY,
	input wire logic I_TEST,
	input wire logic [`KBE_STATIC_W-1:0] I_STATIC_SW,
	input wire logic [2:0] I_SCAN_SLOT,
	output logic O_BUS,
	output logic O_BUS_OE_N,
	output logic [`KBE_CODE_W-1:0] O_CODE,
	output logic O_BUSY1,
	output logic O_BUSY2,
	output logic O_ALARM
);
	initial
	begin
		if (DEBOUNCE_MOD < 4'h1 || DEBOUNCE_MOD > 4'hf)
			$error("debounce modulus out of range");
	end

	localparam int WORDS = 2 * `KBE_KEYS;
	logic [`KBE_CODE_W-1:0] lookup [WORDS];
	always_comb
	begin
		for (int i = 0; i < WORDS; i++)
			lookup[i] = LOOKUP_INIT[i*`KBE_CODE_W +: `KBE_CODE_W];
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// marker, bus and scanned key returns come from logic on this clock; one-bit slots and the
	// scan position of the same cycle would be lost behind a filter, so only the clear key is synced
	logic [2:0] sy_clr_ff;
	logic sync_q, bus_q, key_q, clr_q;
	assign sync_q = I_WORD_SYNC_MARKER;
	assign bus_q = I_BUS;
	assign key_q = I_KEY_RETURN;
	always_ff @(posedge I_MCLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sy_clr_ff <= '0;
			clr_q <= 1'b0;
		end
		else
		begin
			sy_clr_ff <= {sy_clr_ff[1:0], I_CLEAR_KEY};
			if (sy_clr_ff[1] == sy_clr_ff[2])
				clr_q <= sy_clr_ff[2];
		end
	end

	logic sync_d;
	logic sync_rise;
	always_ff @(posedge I_MCLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			sync_d <= 1'b0;
		else
			sync_d <= sync_q;
	end
	assign sync_rise = sync_q & ~sync_d;

	kbe_slot_t slot;
	kbe_slot_timer u_slot
	(
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_sync(sync_rise),
		.o_slot(slot)
	);

	// bus window decode; only bit times 11..30 touch the bus
	logic in_win;
	assign in_win = slot.in_word && slot.slot >= 7'(`KBE_SLOT_FIRST) && slot.slot <= 7'(`KBE_SLOT_LAST);
	logic cmd_xmit, cmd_aset, cmd_arst, cmd_static;
	assign cmd_xmit = in_win && slot.slot == 7'(`KBE_SLOT_XMIT_KEY) && bus_q;
	assign cmd_aset = in_win && slot.slot == 7'(`KBE_SLOT_ALARM_SET) && bus_q;
	assign cmd_arst = in_win && slot.slot == 7'(`KBE_SLOT_ALARM_RST) && bus_q;
	assign cmd_static = in_win && slot.slot == 7'(`KBE_SLOT_STATIC_CMD0) + 7'(STATIC_SLOT_SEL) && bus_q;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		kbe_phase_t phase;
		logic [5:0] mcnt;
		logic [3:0] ecnt;
		logic first_code_latch;
		logic second_code_latch;
		logic busy1;
		logic busy2;
		logic first_sent;
		logic second_sent;
		logic cyc_hit;
		logic pending;
		logic alarm;
		logic [4:0] key_pos;
		logic [4:0] key2_pos;
		logic [`KBE_CODE_W-1:0] code_sr;
		logic [`KBE_CODE_W-1:0] code_out;
		logic [`KBE_STATIC_W-1:0] static_hold;
		logic [`KBE_STATIC_W-1:0] static_sr;
		logic key_tx;
		logic static_tx;
		logic bus_o;
		logic bus_oe_n;
	} kbe_state_t;

	kbe_state_t st_ff;
	kbe_state_t nxt_st;
	logic mwrap;
	logic estep_done;
	logic key_hit_any;
	logic key_seen;

	always_comb
	begin
		nxt_st = st_ff;
		key_hit_any = key_q;
		mwrap = st_ff.mcnt == 6'(`KBE_SCAN_LEN - 1);
		estep_done = I_TEST || (mwrap && !I_SCAN_BLOCK && st_ff.ecnt == DEBOUNCE_MOD - 4'h1);
		// rollover phase counter, stalled with the scan
		if (!I_SCAN_BLOCK)
			nxt_st.mcnt = mwrap ? 6'h0 : st_ff.mcnt + 6'h1;
		if (mwrap && !I_SCAN_BLOCK)
			nxt_st.ecnt = st_ff.ecnt + 4'h1;
		if (I_SCAN_SLOT == 3'(`KBE_STATIC_SAMPLE_SLOT) && !I_SCAN_BLOCK && I_SCAN_POS == 5'h0)
			nxt_st.static_hold = I_STATIC_SW;
		// a full phase cycle without any hit means every key is up
		key_seen = st_ff.cyc_hit || key_hit_any;
		nxt_st.cyc_hit = (mwrap && !I_SCAN_BLOCK) ? 1'b0 : key_seen;
		case (st_ff.phase)
			KBE_IDLE:
			begin
				if (key_hit_any && !st_ff.first_code_latch)
				begin
					nxt_st.first_code_latch = 1'b1;
					nxt_st.busy1 = 1'b1;
					nxt_st.mcnt = I_SCAN_BLOCK ? 6'h0 : 6'h1; // first key sits at phase 0
					nxt_st.ecnt = 4'h0;
					nxt_st.key_pos = I_SCAN_POS;
					nxt_st.phase = KBE_PRESS;
				end
			end
			KBE_PRESS:
			begin
				if (estep_done)
				begin
					nxt_st.code_sr = lookup[{I_UPPER_CASE, st_ff.key_pos}];
					nxt_st.pending = 1'b1;
					nxt_st.phase = KBE_PEND;
				end
			end
			KBE_PEND:
			begin
				if (key_hit_any && st_ff.mcnt != 6'h0 && !st_ff.first_sent)
					nxt_st.alarm = 1'b1;
				if (st_ff.first_sent && !st_ff.pending)
					nxt_st.phase = KBE_HELD;
			end
			KBE_HELD:
			begin
				if (key_hit_any && st_ff.mcnt != 6'h0 && !st_ff.second_code_latch)
				begin
					nxt_st.second_code_latch = 1'b1;
					nxt_st.busy2 = 1'b1;
					nxt_st.second_sent = 1'b0;
					nxt_st.key2_pos = I_SCAN_POS;
					nxt_st.ecnt = 4'h0;
				end
				else if (st_ff.second_code_latch && !st_ff.second_sent && estep_done && !st_ff.pending)
				begin
					nxt_st.code_sr = lookup[{I_UPPER_CASE, st_ff.key2_pos}];
					nxt_st.pending = 1'b1;
					nxt_st.second_sent = 1'b1;
				end
				if (key_hit_any && st_ff.mcnt != 6'h0 && st_ff.second_code_latch && st_ff.key2_pos != I_SCAN_POS)
					nxt_st.alarm = 1'b1;
				// one key up: the first at phase 0, or the second at its own position
				if (st_ff.busy2 && st_ff.second_sent && !st_ff.pending && !key_hit_any && !I_SCAN_BLOCK
					&& (st_ff.mcnt == 6'h0 || I_SCAN_POS == st_ff.key2_pos))
					nxt_st.busy2 = 1'b0;
				// second latch stays until all keys are up, so a held second key is never taken twice
				if (mwrap && !I_SCAN_BLOCK && !key_seen && !st_ff.pending
					&& (!st_ff.second_code_latch || st_ff.second_sent))
				begin
					nxt_st.ecnt = 4'h0;
					nxt_st.phase = KBE_RELEASE;
				end
			end
			KBE_RELEASE:
			begin
				if (key_hit_any)
					nxt_st.phase = KBE_HELD;
				else if (estep_done)
				begin
					nxt_st.first_code_latch = 1'b0;
					nxt_st.busy1 = 1'b0;
					nxt_st.busy2 = 1'b0;
					nxt_st.second_code_latch = 1'b0;
					nxt_st.first_sent = 1'b0;
					nxt_st.second_sent = 1'b0;
					nxt_st.phase = KBE_IDLE;
				end
			end
			default:
				nxt_st.phase = KBE_IDLE;
		endcase
		// key send: 9 bits in slots 22..30 of the same word
		if (cmd_xmit && st_ff.pending)
		begin
			nxt_st.key_tx = 1'b1;
			nxt_st.pending = 1'b0;
			nxt_st.first_sent = 1'b1;
			nxt_st.code_out = st_ff.code_sr;
		end
		if (cmd_static)
		begin
			nxt_st.static_tx = 1'b1;
			nxt_st.static_sr = st_ff.static_hold;
		end
		nxt_st.bus_o = 1'b0;
		nxt_st.bus_oe_n = 1'b1;
		if (in_win)
		begin
			if (slot.slot == 7'(`KBE_SLOT_PENDING) - 7'h1 && st_ff.pending)
			begin
				nxt_st.bus_o = 1'b1;
				nxt_st.bus_oe_n = 1'b0;
			end
			if (slot.slot == 7'(`KBE_SLOT_ALARM_OUT) - 7'h1 && st_ff.alarm && ALARM_ON_BUS)
			begin
				nxt_st.bus_o = 1'b1;
				nxt_st.bus_oe_n = 1'b0;
			end
			if (slot.slot >= 7'(`KBE_SLOT_DATA0) - 7'h1 && slot.slot < 7'(`KBE_SLOT_LAST))
			begin
				if (st_ff.key_tx)
				begin
					nxt_st.bus_o = st_ff.code_out[0];
					nxt_st.bus_oe_n = 1'b0;
					nxt_st.code_out = {1'b0, st_ff.code_out[`KBE_CODE_W-1:1]};
				end
				else if (st_ff.static_tx && slot.slot < 7'(`KBE_SLOT_DATA0 + `KBE_STATIC_W) - 7'h1)
				begin
					nxt_st.bus_o = st_ff.static_sr[0];
					nxt_st.bus_oe_n = 1'b0;
					nxt_st.static_sr = {1'b0, st_ff.static_sr[`KBE_STATIC_W-1:1]};
				end
			end
		end
		if (slot.slot == 7'(`KBE_SLOT_LAST) && slot.in_word)
		begin
			nxt_st.key_tx = 1'b0;
			nxt_st.static_tx = 1'b0;
		end
		// bus set wins over clear
		if (clr_q || cmd_arst)
			nxt_st.alarm = 1'b0;
		if (cmd_aset)
			nxt_st.alarm = 1'b1;
		if (key_hit_any && st_ff.mcnt != 6'h0 && st_ff.phase == KBE_PEND && !st_ff.first_sent)
			nxt_st.alarm = 1'b1;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			st_ff <= '0;
			st_ff.phase <= KBE_IDLE;
			st_ff.bus_oe_n <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_BUS <= 1'b0;
			O_BUS_OE_N <= 1'b1;
			O_CODE <= '0;
			O_BUSY1 <= 1'b0;
			O_BUSY2 <= 1'b0;
			O_ALARM <= 1'b0;
		end
		else
		begin
			O_BUS <= nxt_st.bus_o;
			O_BUS_OE_N <= nxt_st.bus_oe_n;
			O_CODE <= nxt_st.code_sr;
			O_BUSY1 <= nxt_st.busy1;
			O_BUSY2 <= nxt_st.busy2;
			O_ALARM <= nxt_st.alarm;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_mwrap;
		@(posedge I_MCLK) disable iff (!I_RST_N) st_ff.mcnt <= 6'(`KBE_SCAN_LEN - 1);
	endproperty
	a_mwrap: assert property (p_mwrap) else $error("phase counter over modulus");
	property p_stall;
		@(posedge I_MCLK) disable iff (!I_RST_N) I_SCAN_BLOCK && st_ff.phase != KBE_IDLE |=> $stable(st_ff.mcnt);
	endproperty
	a_stall: assert property (p_stall) else $error("phase counter moved while blocked");
	property p_win;
		@(posedge I_MCLK) disable iff (!I_RST_N) !O_BUS_OE_N |-> $past(in_win);
	endproperty
	a_win: assert property (p_win) else $error("bus driven outside window");
	property p_pend;
		@(posedge I_MCLK) disable iff (!I_RST_N) cmd_xmit && st_ff.pending |=> !st_ff.pending && st_ff.key_tx;
	endproperty
	a_pend: assert property (p_pend) else $error("send not taken");
	property p_aset;
		@(posedge I_MCLK) disable iff (!I_RST_N) cmd_aset |=> O_ALARM;
	endproperty
	a_aset: assert property (p_aset) else $error("alarm set ignored");
	property p_arst;
		@(posedge I_MCLK) disable iff (!I_RST_N) cmd_arst && !cmd_aset && !key_hit_any |=> !O_ALARM;
	endproperty
	a_arst: assert property (p_arst) else $error("alarm reset ignored");
	property p_busy;
		@(posedge I_MCLK) disable iff (!I_RST_N) O_BUSY2 |-> O_BUSY1;
	endproperty
	a_busy: assert property (p_busy) else $error("busy two without busy one");
	property p_load;
		@(posedge I_MCLK) disable iff (!I_RST_N) st_ff.phase == KBE_PRESS && estep_done |=> st_ff.pending ##1 O_CODE == $past(st_ff.code_sr);
	endproperty
	a_load: assert property (p_load) else $error("code not loaded");
	c_send: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) cmd_xmit && st_ff.pending);
	c_alarm: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) $rose(O_ALARM));
	c_second: cover property (@(posedge I_MCLK) disable iff (!I_RST_N) $rose(O_BUSY2));
endmodule
`default_nettype wire

//--- kbe_cfg.svh
// constants for the keyboard encoder housekeeping block
`ifndef KBE_CFG_SVH
`define KBE_CFG_SVH
`define KBE_CODE_W 9
`define KBE_KEYS 32
`define KBE_SCAN_LEN 33
`define KBE_WORD_LEN 76
`define KBE_SLOT_FIRST 11
`define KBE_SLOT_LAST 30
`define KBE_SLOT_XMIT_KEY 12
`define KBE_SLOT_ALARM_SET 13
`define KBE_SLOT_ALARM_RST 14
`define KBE_SLOT_STATIC_CMD0 15
`define KBE_SLOT_ALARM_OUT 19
`define KBE_SLOT_PENDING 20
`define KBE_SLOT_DATA0 22
`define KBE_STATIC_SAMPLE_SLOT 5
`define KBE_DEBOUNCE_DEF 10
`define KBE_STATIC_W 8
`endif

//--- kbe_pkg.sv
// types for the keyboard encoder housekeeping block
`default_nettype none
package kbe_pkg;
	typedef enum logic [2:0]
	{
		KBE_IDLE = 3'h0,
		KBE_PRESS = 3'h1,
		KBE_PEND = 3'h3,
		KBE_HELD = 3'h2,
		KBE_RELEASE = 3'h6
	} kbe_phase_t;

	typedef struct packed
	{
		logic [6:0] slot;
		logic in_word;
	} kbe_slot_t;
endpackage
`default_nettype wire

//--- kbe_slot_timer.sv
// bit-time counter locked to the word sync marker
`timescale 1ns/1ns
`default_nettype none
`include "kbe_cfg.svh"
module kbe_slot_timer
	import kbe_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sync,
	output var kbe_slot_t o_slot
);
	kbe_slot_t st_ff;
	kbe_slot_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (i_sync)
		begin
			nxt_st.slot = 7'h0;
			nxt_st.in_word = 1'b1;
		end
		else if (st_ff.in_word)
		begin
			if (st_ff.slot == 7'(`KBE_WORD_LEN - 1))
				nxt_st.in_word = 1'b0;
			else
				nxt_st.slot = st_ff.slot + 7'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_slot = st_ff;
endmodule
`default_nettype wire

//--- kbe_tc_model.sv
// timing and control partner: word sync, bus commands, capture of device bus traffic
`timescale 1ns/1ns
`default_nettype none
module kbe_tc_model #(
	parameter int CMD_LEAD = 1
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_auto,
	input wire logic [1:0] i_req,
	input wire logic i_dev_bus,
	input wire logic i_dev_oe_n,
	output logic o_sync,
	output logic o_bus,
	output logic o_frame_v,
	output logic [8:0] o_frame,
	output logic o_alarm_seen,
	output logic o_stray
);
	logic [6:0] wc;
	logic [6:0] pw;
	logic [6:0] rel;
	logic [8:0] sh;
	logic [3:0] nb;
	logic [1:0] req;
	logic [1:0] cur;
	logic cal;
	logic seen;
	logic ksend;
	logic drv;

	// ----------------------------------------
	// bus drive
	// ----------------------------------------
	// cmd_lead covers the device's slot count starting one clock after the marker
	assign rel = wc - 7'(CMD_LEAD);
	assign drv = (ksend && rel == 7'd12) || (cur != 2'h0 && rel == 7'd12 + 7'(cur));
	// command slots are always driven; elsewhere a released wire toggles
	assign o_bus = !i_dev_oe_n ? i_dev_bus : (rel >= 7'd12 && rel <= 7'd18) ? drv : wc[0];
	assign o_sync = i_rst_n && wc == 7'd0;

	// ----------------------------------------
	// word timing and capture
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wc <= 7'd70;
			pw <= '0;
			sh <= '0;
			nb <= '0;
			req <= '0;
			cur <= '0;
			cal <= 1'b0;
			seen <= 1'b0;
			ksend <= 1'b0;
			o_frame_v <= 1'b0;
			o_frame <= '0;
			o_alarm_seen <= 1'b0;
			o_stray <= 1'b0;
		end
		else
		begin
			wc <= (wc == 7'd75) ? 7'd0 : wc + 7'd1;
			o_frame_v <= 1'b0;
			o_alarm_seen <= 1'b0;
			o_stray <= 1'b0;
			if (wc == 7'd75)
			begin
				ksend <= i_auto && seen;
				seen <= 1'b0;
				// a static send waits for a word without a key send
				if (!(i_auto && seen && req == 2'h3))
				begin
					cur <= req;
					req <= 2'h0;
				end
				else
					cur <= 2'h0;
			end
			if (i_req != 2'h0)
				req <= i_req;
			// the first drive after reset is the pending bit and fixes the slot grid
			if (!i_dev_oe_n)
			begin
				if (!cal || wc == pw)
				begin
					cal <= 1'b1;
					pw <= wc;
					seen <= 1'b1;
				end
				else if (wc == pw - 7'd1)
					o_alarm_seen <= i_dev_bus;
				else if (wc >= pw + 7'd2 && wc <= pw + 7'd10)
				begin
					sh <= {i_dev_bus, sh[8:1]};
					nb <= nb + 4'd1;
				end
				else
					o_stray <= 1'b1;
			end
			if (cal && wc == pw + 7'd11 && nb != 4'd0)
			begin
				o_frame_v <= 1'b1;
				o_frame <= (nb == 4'd9) ? sh : {1'b0, sh[8:1]};
				nb <= 4'd0;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the keyboard encoder housekeeping core
`timescale 1ns/1ns
`default_nettype none
`include "kbe_cfg.svh"
module tb;
	localparam int LUT_W = `KBE_CODE_W * 64;
	function automatic logic [8:0] code_of(input logic [5:0] i);
		code_of = (9'(i) * 9'h01d) ^ 9'h0a5;
	endfunction
	function automatic logic [LUT_W-1:0] mk_lut();
		for (int i = 0; i < 64; i++)
			mk_lut[i*9 +: 9] = code_of(6'(i));
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		xs = r ^ (r << 5);
	endfunction
	localparam logic [LUT_W-1:0] LUT = mk_lut();

	logic clk = 1'b0, rst_n = 1'b0, blk = 1'b0, upper = 1'b0, clr = 1'b0, tst = 1'b0, auto = 1'b0;
	logic sync, bus_in, key_ret, obus, oe_n, b1, b2, alm, fv, aseen, stray;
	logic [1:0] req = 2'h0;
	logic [7:0] st = 8'h00;
	logic [31:0] keys = '0;
	logic [31:0] rnd = 32'hfd37;
	logic [5:0] cnt = 6'd0;
	logic [8:0] frame;
	logic [8:0] code;
	logic [4:0] k;
	logic [8:0] expq[$];
	int err_count = 0, samples_checked = 0, acount = 0;

	assign key_ret = cnt < 6'd32 && keys[cnt[4:0]];

	kbe_core #(.DEBOUNCE_MOD(4'hf), .LOOKUP_INIT(LUT)) u_kbe_core (
		.I_MCLK(clk), .I_RST_N(rst_n), .I_WORD_SYNC_MARKER(sync), .I_BUS(bus_in),
		.I_KEY_RETURN(key_ret), .I_SCAN_POS(cnt[4:0]), .I_SCAN_BLOCK(blk), .I_UPPER_CASE(upper),
		.I_CLEAR_KEY(clr), .I_TEST(tst), .I_STATIC_SW(st), .I_SCAN_SLOT(3'h5), .O_BUS(obus),
		.O_BUS_OE_N(oe_n), .O_CODE(code), .O_BUSY1(b1), .O_BUSY2(b2), .O_ALARM(alm));
	kbe_tc_model u_kbe_tc_model (
		.i_clk(clk), .i_rst_n(rst_n), .i_auto(auto), .i_req(req), .i_dev_bus(obus), .i_dev_oe_n(oe_n),
		.o_sync(sync), .o_bus(bus_in), .o_frame_v(fv), .o_frame(frame), .o_alarm_seen(aseen), .o_stray(stray));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: sig = b1;
			1: sig = b2;
			2: sig = alm;
			default: sig = expq.size() == 0;
		endcase
	endfunction
	task automatic waitv(input int w, input logic v, input int lim);
		for (int i = 0; sig(w) !== v; i++)
		begin
			if (i == lim)
			begin
				err_count++;
				stop_test();
			end
			tick(1);
		end
	endtask
	task automatic press(input logic [4:0] k);
		keys[k] = 1'b1;
		expq.push_back(code_of({upper, k}));
	endtask
	task automatic cmd(input logic [1:0] c);
		req = c;
		tick(1);
		req = 2'h0;
	endtask

	// ----------------------------------------
	// clock, scan model, monitor
	// ----------------------------------------
	initial
	begin
		forever #5 clk = ~clk;
	end
	// the settle stall freezes the scan position just as it freezes the rollover phase
	always @(posedge clk)
	begin
		#1;
		if (!blk)
			cnt = (cnt == 6'd32) ? 6'd0 : cnt + 6'd1;
		rnd = xs(rnd);
		blk = rnd[3:0] == 4'h0;
	end
	always @(posedge clk)
	begin
		if (fv)
			chk("frame", frame, (expq.size() != 0) ? expq.pop_front() : 9'h1ff);
		if (aseen)
			acount++;
		if (stray)
			chk("stray drive", 9'h1, 9'h0);
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		tick(5);
		chk("reset outs", {5'h0, oe_n, b1, b2, alm}, 9'h008);
		tick(5);
		rst_n = 1'b1;
		auto = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			upper = i[0];
			k = rnd[12:8];
			press(k);
			tick(60);
			chk("busy1", 9'(b1), 9'h1);
			tick(240);
			chk("early send", 9'(expq.size()), 9'h1);
			waitv(3, 1'b1, 3000);
			chk("code reg", code, code_of({upper, k}));
			keys = '0;
			tick(300);
			chk("busy1 hold", 9'(b1), 9'h1);
			waitv(0, 1'b0, 3000);
		end
		st = rnd[7:0];
		tick(200);
		expq.push_back({1'b0, st});
		cmd(2'h3);
		waitv(3, 1'b1, 1000);
		press(5'h03);
		waitv(3, 1'b1, 3000);
		press(5'h11);
		waitv(1, 1'b1, 500);
		waitv(3, 1'b1, 3000);
		keys[3] = 1'b0;
		waitv(1, 1'b0, 3000);
		chk("busy1 rollover", 9'(b1), 9'h1);
		keys = '0;
		waitv(0, 1'b0, 3000);
		chk("alarm bits", 9'(acount), 9'h0);
		auto = 1'b0;
		press(5'h07);
		tick(1200);
		keys[9] = 1'b1;
		waitv(2, 1'b1, 500);
		keys[9] = 1'b0;
		tick(160);
		chk("alarm on bus", 9'(acount != 0), 9'h1);
		cmd(2'h2);
		waitv(2, 1'b0, 300);
		auto = 1'b1;
		waitv(3, 1'b1, 3000);
		keys = '0;
		waitv(0, 1'b0, 3000);
		cmd(2'h1);
		waitv(2, 1'b1, 300);
		clr = 1'b1;
		waitv(2, 1'b0, 50);
		clr = 1'b0;
		tst = 1'b1;
		press(5'h1f);
		waitv(3, 1'b1, 400);
		keys = '0;
		waitv(0, 1'b0, 400);
		tst = 1'b0;
		tick(100);
		stop_test();
	end
endmodule
`default_nettype wire
